// File: verilog/pin_ctrl_pkg.sv
// Constants, register map and field layout of the pin-control block
// Overview of operation
// - Mux-control bit drives pins as mux selects
// - Sequencer handles at most four channels
// - Sync enable: low pin holds modulator reset
// - Alternate sync only with several channels enabled
// - Alternate sync: low pin stalls channel switch
// - Error mode field: off, input, open-drain, output
// - Error input: inverted pin ORed into error
// - Open-drain output pulls low on any error
// - Output mode drives pin actively from data bit
// - Error data bit: drive level or readback
// - Input enables bits 5 and 4, reset zero
// - Output enables bits 3 and 2, reset zero
// - Data bits 1 and 0: write drive, read pin when input-enabled and not driven
// - Bits 7 and 6 reserved, read zero
package pin_ctrl_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 12;
  localparam int          CFG_W           = 16;
  // Register byte addresses
  localparam logic [11:0] ADDR_CONFIG     = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h010;
  // Configuration field positions
  localparam int          BIT_MUX_CTRL    = 12;
  localparam int          BIT_SYNC_EN     = 11;
  localparam int          BIT_ERR_MODE_HI = 10;
  localparam int          BIT_ERR_MODE_LO = 9;
  localparam int          BIT_ERR_LEVEL   = 8;
  localparam int          BIT_IN_EN1      = 5;
  localparam int          BIT_IN_EN0      = 4;
  localparam int          BIT_OUT_EN1     = 3;
  localparam int          BIT_OUT_EN0     = 2;
  localparam int          BIT_LEVEL1      = 1;
  localparam int          BIT_LEVEL0      = 0;
  // Writable bits; 15:13 and 7:6 read as zero
  localparam logic [15:0] CFG_WMASK       = 16'h1f3f;
  localparam logic [15:0] CFG_RESET       = 16'h0800;
  // Error pin modes
  localparam logic [1:0]  ERR_OFF         = 2'h0;
  localparam logic [1:0]  ERR_INPUT       = 2'h1;
  localparam logic [1:0]  ERR_OPEN_DRAIN  = 2'h2;
  localparam logic [1:0]  ERR_GP_OUT      = 2'h3;
  // Status register fields
  localparam int          ST_CONV_ERR     = 0;
  localparam int          ST_HOLD         = 1;
  localparam int          ST_STALL        = 2;
  // Interrupt event bits
  localparam int          IRQ_W           = 3;
  localparam int          EV_ERROR        = 0;
  localparam int          EV_SYNC_FALL    = 1;
  localparam int          EV_SYNC_RISE    = 2;
  localparam int          MAX_SEQ_CH      = 4;
endpackage : pin_ctrl_pkg

// File: verilog/pin_ctrl.sv
// Pin control of the two general pins and the sync/error pin, APB slave
//
// Implementation choices: the register addresses and the APB slave port.
module pin_ctrl
  import pin_ctrl_pkg::*;
#(
  parameter int N_CH = MAX_SEQ_CH
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        gp_pin_in,
  output logic      [1:0]        gp_pin_out,
  output logic      [1:0]        gp_pin_oe,
  input  wire logic              sync_err_in,
  output logic                   sync_err_out,
  output logic                   sync_err_oe,
  input  wire logic [1:0]        seq_channel,
  input  wire logic              seq_switch_due,
  input  wire logic [N_CH-1:0]   channel_enable,
  input  wire logic              alternate_sync_sel,
  input  wire logic              device_error,
  output logic                   modulator_hold,
  output logic                   sequencer_stall,
  output logic                   conv_error,
  output logic                   irq
);

  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              sync_prev;
    logic              err_prev;
    logic              stall;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              slverr;
    logic [1:0]        gp_out;
    logic [1:0]        gp_oe;
    logic              se_out;
    logic              se_oe;
    logic              hold;
    logic              cerr;
    logic              irq;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic             ext_mux_ctrl_en;
  logic             sync_en;
  logic [1:0]       err_mode;
  logic             error_pin_level;
  logic [1:0]       input_en;
  logic [1:0]       output_en;
  logic [1:0]       pin_level;
  logic             multi_ch;
  logic             alt_active;
  logic             err_in_term;
  logic             any_error;
  logic             access;
  logic [IRQ_W-1:0] events;

  // Field views of the configuration word
  assign ext_mux_ctrl_en = st_reg.cfg[BIT_MUX_CTRL];
  assign sync_en         = st_reg.cfg[BIT_SYNC_EN];
  assign err_mode        = st_reg.cfg[BIT_ERR_MODE_HI:BIT_ERR_MODE_LO];
  assign error_pin_level = st_reg.cfg[BIT_ERR_LEVEL];
  assign input_en        = {st_reg.cfg[BIT_IN_EN1], st_reg.cfg[BIT_IN_EN0]};
  assign output_en       = {st_reg.cfg[BIT_OUT_EN1], st_reg.cfg[BIT_OUT_EN0]};
  assign pin_level       = {st_reg.cfg[BIT_LEVEL1], st_reg.cfg[BIT_LEVEL0]};
  assign access          = psel & penable & ~st_reg.ready;

  // More than one enabled channel turns on sequencing
  assign multi_ch    = ($countones(channel_enable) > 1);
  assign alt_active  = sync_en & alternate_sync_sel & multi_ch;
  // Error input: pin is active low, so invert before merging
  assign err_in_term = (err_mode == ERR_INPUT) & ~sync_err_in;
  assign any_error   = device_error | err_in_term;

  always_comb begin
    st_next = st_reg;
    events  = '0;
    st_next.sync_prev = sync_err_in;
    st_next.err_prev  = any_error;
    st_next.ready     = 1'b0;
    st_next.slverr    = 1'b0;

    // Immediate sync holds the modulator while the pin is low
    st_next.hold = sync_en & ~alt_active & ~sync_err_in;
    // Alternate sync: a switch while low stalls until the pin rises
    if (!alt_active) begin
      st_next.stall = 1'b0;
    end else if (st_reg.stall && sync_err_in && !st_reg.sync_prev) begin
      st_next.stall = 1'b0;
    end else if (seq_switch_due && !sync_err_in) begin
      st_next.stall = 1'b1;
    end
    st_next.cerr = any_error;

    // General pins; mux selects take priority over data bits
    for (int i = 0; i < 2; i++) begin
      if (ext_mux_ctrl_en) begin
        st_next.gp_oe[i]  = 1'b1;
        st_next.gp_out[i] = seq_channel[i];
      end else begin
        st_next.gp_oe[i]  = output_en[i];
        st_next.gp_out[i] = pin_level[i];
      end
    end

    // Sync/error pin drive by error mode
    unique case (err_mode)
      ERR_OPEN_DRAIN: begin
        st_next.se_out = 1'b0;
        st_next.se_oe  = device_error;
      end
      ERR_GP_OUT: begin
        st_next.se_out = error_pin_level;
        st_next.se_oe  = 1'b1;
      end
      ERR_OFF, ERR_INPUT: begin
        st_next.se_out = 1'b0;
        st_next.se_oe  = 1'b0;
      end
    endcase

    // Interrupt events; a set in the clear cycle wins
    events[EV_ERROR]     = any_error & ~st_reg.err_prev;
    events[EV_SYNC_FALL] = ~sync_err_in & st_reg.sync_prev;
    events[EV_SYNC_RISE] = sync_err_in & ~st_reg.sync_prev;

    // APB access, answered one cycle after the access phase begins
    if (access) begin
      st_next.ready = 1'b1;
      st_next.rdata = '0;
      if (pwrite) begin
        unique case (paddr)
          ADDR_CONFIG: st_next.cfg = pwdata[CFG_W-1:0] & CFG_WMASK;
          ADDR_IRQ_ENABLE: st_next.irq_en = pwdata[IRQ_W-1:0];
          ADDR_IRQ_CLEAR: st_next.irq_stat = st_reg.irq_stat & ~pwdata[IRQ_W-1:0];
          ADDR_STATUS, ADDR_IRQ_STATUS: st_next.slverr = 1'b1;
          default: st_next.slverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          ADDR_CONFIG: begin
            st_next.rdata[CFG_W-1:0] = st_reg.cfg;
            // Input pins read back their sampled level
            for (int i = 0; i < 2; i++) begin
              if (input_en[i] && !(output_en[i] || ext_mux_ctrl_en)) begin
                st_next.rdata[BIT_LEVEL0 + i] = gp_pin_in[i];
              end
            end
            if (err_mode == ERR_INPUT || (sync_en && err_mode == ERR_OFF)) begin
              st_next.rdata[BIT_ERR_LEVEL] = sync_err_in;
            end
          end
          ADDR_STATUS: begin
            st_next.rdata[ST_CONV_ERR] = st_reg.cerr;
            st_next.rdata[ST_HOLD]     = st_reg.hold;
            st_next.rdata[ST_STALL]    = st_reg.stall;
          end
          ADDR_IRQ_STATUS: st_next.rdata[IRQ_W-1:0] = st_reg.irq_stat;
          ADDR_IRQ_ENABLE: st_next.rdata[IRQ_W-1:0] = st_reg.irq_en;
          ADDR_IRQ_CLEAR: st_next.rdata = '0;
          default: st_next.slverr = 1'b1;
        endcase
      end
    end
    st_next.irq_stat = st_next.irq_stat | events;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.cfg       <= CFG_RESET;
      st_reg.sync_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register
  assign prdata          = st_reg.rdata;
  assign pready          = st_reg.ready;
  assign pslverr         = st_reg.slverr;
  assign gp_pin_out      = st_reg.gp_out;
  assign gp_pin_oe       = st_reg.gp_oe;
  assign sync_err_out    = st_reg.se_out;
  assign sync_err_oe     = st_reg.se_oe;
  assign modulator_hold  = st_reg.hold;
  assign sequencer_stall = st_reg.stall;
  assign conv_error      = st_reg.cerr;
  assign irq             = st_reg.irq;

endmodule : pin_ctrl

// File: verification/pin_ctrl_monitor.sv
// Port-level assertions for the pin-control block
module pin_ctrl_monitor #(
  parameter int N_CH = 4
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            sync_err_in,
  input wire logic            seq_switch_due,
  input wire logic [N_CH-1:0] channel_enable,
  input wire logic            alternate_sync_sel,
  input wire logic            device_error,
  input wire logic            modulator_hold,
  input wire logic            sequencer_stall,
  input wire logic            conv_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Bus answer comes one cycle into the access phase and lasts one cycle
  ready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // Hold and stall only follow a low pin seen one edge before
  hold_pin_low_a: assert property (modulator_hold |-> $past(!sync_err_in))
    else $error("hold without low pin");
  stall_cause_a: assert property ($rose(sequencer_stall) |->
    $past(seq_switch_due && !sync_err_in && alternate_sync_sel)) else $error("bad stall");
  stall_multi_a: assert property ($rose(sequencer_stall) |->
    $past($countones(channel_enable) > 1)) else $error("stall with one channel");
  stall_release_a: assert property ($fell(sequencer_stall) |-> $past(sync_err_in))
    else $error("stall released while low");
  error_flag_a: assert property (device_error |=> conv_error)
    else $error("error flag missing");
  cover property (modulator_hold);
  cover property (sequencer_stall);
  cover property (pslverr);
endmodule : pin_ctrl_monitor

// File: verification/pin_partner.sv
// Far side of the pins: external mux inputs and a wired error line
module pin_partner (
  input  wire logic [1:0] gp_pin_out,
  input  wire logic [1:0] gp_pin_oe,
  input  wire logic [1:0] far_gp,
  input  wire logic       sync_err_out,
  input  wire logic       sync_err_oe,
  input  wire logic       far_low,
  output logic      [1:0] gp_pin_in,
  output logic            sync_err_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared pull-up line: any party pulling low wins
  assign sync_err_in = !(far_low || (sync_err_oe && !sync_err_out));
  // A driven pin shows its own level, otherwise the far side drives it
  assign gp_pin_in = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & far_gp);
endmodule : pin_partner

// File: verification/pin_ctrl_tb.sv
// Self-checking bench for the pin-control block
module pin_ctrl_tb;
  import pin_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic        sync_err_in, sync_err_out, sync_err_oe, seq_switch_due, alternate_sync_sel;
  logic        device_error, modulator_hold, sequencer_stall, conv_error, irq, far_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  gp_pin_in, gp_pin_out, gp_pin_oe, seq_channel, far_gp;
  logic [3:0]  channel_enable;
  int          checks, fails;
  pin_ctrl #(.N_CH(4)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
    .sync_err_in(sync_err_in), .sync_err_out(sync_err_out), .sync_err_oe(sync_err_oe),
    .seq_channel(seq_channel), .seq_switch_due(seq_switch_due),
    .channel_enable(channel_enable), .alternate_sync_sel(alternate_sync_sel),
    .device_error(device_error), .modulator_hold(modulator_hold),
    .sequencer_stall(sequencer_stall), .conv_error(conv_error), .irq(irq)
  );
  pin_partner u_far (
    .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe), .far_gp(far_gp),
    .sync_err_out(sync_err_out), .sync_err_oe(sync_err_oe), .far_low(far_low),
    .gp_pin_in(gp_pin_in), .sync_err_in(sync_err_in)
  );
  // Clock, 8 ns period
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic t_regs;
    apb(0, ADDR_CONFIG, 0);
    // Sync input is on after reset, so bit 8 reads back the idle-high pin
    check(rd, 32'h0000_0900);
    check(32'(gp_pin_oe), 0);
    apb(1, ADDR_CONFIG, 32'h0000_0030);
    apb(0, ADDR_CONFIG, 0);
    check(rd, 32'h0000_0031);
    apb(1, ADDR_CONFIG, 32'h0000_ffff);
    apb(0, ADDR_CONFIG, 0);
    check(rd, 32'h0000_1f3f);
    check({sync_err_oe, sync_err_out}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      seq_channel <= 2'(i);
      settle();
      check({gp_pin_oe, gp_pin_out}, {2'b11, 2'(i)});
    end
    apb(1, ADDR_CONFIG, 32'h0000_000e);
    settle();
    check({gp_pin_oe, gp_pin_out}, 4'b1110);
    apb(0, 12'h020, 0);
    check(32'(er), 1);
    apb(1, ADDR_STATUS, 0);
    check(32'(er), 1);
  endtask : t_regs
  task automatic t_err;
    // Stored level bit is 1, so a 0 on read proves the pin is shown
    apb(1, ADDR_CONFIG, 32'h0000_0300);
    far_low <= 1'b1;
    settle();
    check(32'(conv_error), 1);
    apb(0, ADDR_CONFIG, 0);
    check(rd, 32'h0000_0200);
    apb(1, ADDR_CONFIG, 0);
    settle();
    check(32'(conv_error), 0);
    far_low <= 1'b0;
    apb(1, ADDR_CONFIG, 32'h0000_0400);
    device_error <= 1'b1;
    settle();
    check({sync_err_oe, sync_err_out, sync_err_in}, 3'b100);
    @(posedge clk);
    device_error <= 1'b0;
    settle();
    check(32'(sync_err_oe), 0);
  endtask : t_err
  task automatic t_sync;
    apb(1, ADDR_CONFIG, 32'h0000_0800);
    far_low <= 1'b1;
    settle();
    check(32'(modulator_hold), 1);
    {alternate_sync_sel, channel_enable} <= 5'b10011;
    settle();
    check(32'(modulator_hold), 0);
    @(posedge clk);
    seq_switch_due <= 1'b1;
    @(posedge clk);
    seq_switch_due <= 1'b0;
    settle();
    check(32'(sequencer_stall), 1);
    apb(0, ADDR_STATUS, 0);
    check(rd, 32'h0000_0004);
    far_low <= 1'b0;
    settle();
    check(32'(sequencer_stall), 0);
    {far_low, channel_enable} <= 5'b10001;
    settle();
    check(32'(modulator_hold), 1);
    far_low <= 1'b0;
  endtask : t_sync
  // Interrupt raised, read, cleared and masked
  task automatic t_irq;
    apb(1, ADDR_IRQ_ENABLE, 1);
    apb(1, ADDR_IRQ_CLEAR, 7);
    device_error <= 1'b1;
    settle();
    check(32'(irq), 1);
    apb(0, ADDR_IRQ_STATUS, 0);
    check(32'(rd[0]), 1);
    device_error <= 1'b0;
    apb(1, ADDR_IRQ_CLEAR, 1);
    settle();
    check(32'(irq), 0);
    apb(1, ADDR_IRQ_ENABLE, 0);
    device_error <= 1'b1;
    settle();
    check(32'(irq), 0);
  endtask : t_irq
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    // One channel, immediate sync; the far side drives 01 on undriven pins
    {reset, psel, penable, pwrite, seq_switch_due, alternate_sync_sel} = 6'b100000;
    {paddr, pwdata, seq_channel} = '0;
    {device_error, far_low, far_gp, channel_enable} = 8'b0001_0001;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_err();
    t_sync();
    t_irq();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
endmodule : pin_ctrl_tb
bind pin_ctrl pin_ctrl_monitor #(.N_CH(N_CH)) u_mon (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .sync_err_in(sync_err_in),
  .seq_switch_due(seq_switch_due), .channel_enable(channel_enable),
  .alternate_sync_sel(alternate_sync_sel), .device_error(device_error),
  .modulator_hold(modulator_hold), .sequencer_stall(sequencer_stall), .conv_error(conv_error));
